/* File: cx_exec_core.sv */
// Execute core for the return, sleep, rotate, subtract, swap, direction and xor subset
`timescale 1ns/1ps
module cx_exec_core (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire cx_pkg::cx_bus_req_t bus_req,
   output logic [cx_pkg::BUS_DW-1:0] bus_rdata,
   input wire cx_pkg::cx_inst_t inst,
   output logic inst_ready,
   input wire logic wake_pin,
   output logic osc_run,
   output logic [cx_pkg::PC_W-1:0] pc_out,
   output cx_pkg::cx_dir_t dir_out
);
   cx_pkg::cx_state_t st;
   cx_pkg::cx_state_t next_st;
   cx_pkg::cx_op_t op;
   cx_pkg::cx_alu_out_t alu;
   logic taken;
   logic dest_file;
   logic [4:0] fidx;
   logic [cx_pkg::DATA_W-1:0] fval;
   logic [cx_pkg::DATA_W-1:0] lit;
   logic wdt_ovf;

   function automatic cx_pkg::cx_op_t decode(input logic [cx_pkg::INST_W-1:0] w);
      cx_pkg::cx_op_t d;
      d = cx_pkg::OP_NONE;
      if ((w & cx_pkg::MASK_LIT) == cx_pkg::OPC_RET) d = cx_pkg::OP_RET;
      else if ((w & cx_pkg::MASK_LIT) == cx_pkg::OPC_XORL) d = cx_pkg::OP_XORL;
      else if ((w & cx_pkg::MASK_ALL) == cx_pkg::OPC_SLEEP) d = cx_pkg::OP_SLEEP;
      else if ((w & cx_pkg::MASK_DIR) == cx_pkg::OPC_DIR) d = cx_pkg::OP_DIR;
      else if ((w & cx_pkg::MASK_FD) == cx_pkg::OPC_RL) d = cx_pkg::OP_RL;
      else if ((w & cx_pkg::MASK_FD) == cx_pkg::OPC_RR) d = cx_pkg::OP_RR;
      else if ((w & cx_pkg::MASK_FD) == cx_pkg::OPC_SUB) d = cx_pkg::OP_SUB;
      else if ((w & cx_pkg::MASK_FD) == cx_pkg::OPC_SWAP) d = cx_pkg::OP_SWAP;
      else if ((w & cx_pkg::MASK_FD) == cx_pkg::OPC_XORF) d = cx_pkg::OP_XORF;
      return d;
   endfunction

   function automatic logic [cx_pkg::DATA_W-1:0] pack_status(input cx_pkg::cx_state_t s);
      logic [cx_pkg::DATA_W-1:0] v;
      v = '0;
      v[cx_pkg::ST_C] = s.c;
      v[cx_pkg::ST_DC] = s.dc;
      v[cx_pkg::ST_Z] = s.z;
      v[cx_pkg::ST_SLEPT_N] = s.slept_n;
      v[cx_pkg::ST_TO_N] = s.to_n;
      v[cx_pkg::ST_WAKE] = s.wake_flag;
      return v;
   endfunction

   assign op = decode(inst.word);
   assign taken = inst.valid && st.inst_ready;
   assign fidx = inst.word[4:0];
   assign dest_file = inst.word[cx_pkg::INST_D_BIT];
   assign fval = st.file[fidx];
   assign lit = inst.word[7:0];
   assign wdt_ovf = (&st.wdt) && (&st.pre);

   cx_alu u_alu (
      .op(op),
      .acc(st.acc),
      .fval(fval),
      .lit(lit),
      .c_in(st.c),
      .res(alu)
   );

   always_comb begin
      next_st = st;
      next_st.wk_s1 = wake_pin;
      next_st.wk_s2 = st.wk_s1;
      next_st.rd_data = '0;

      // Register reads: data stand in the next cycle only
      if (bus_req.rd) begin
         if (!bus_req.addr[cx_pkg::ADDR_FILE_BIT]) begin
            next_st.rd_data = cx_pkg::BUS_DW'(st.file[bus_req.addr[4:0]]);
         end else begin
            case (bus_req.addr)
               cx_pkg::ADDR_ACC: next_st.rd_data = cx_pkg::BUS_DW'(st.acc);
               cx_pkg::ADDR_STATUS: next_st.rd_data = cx_pkg::BUS_DW'(pack_status(st));
               cx_pkg::ADDR_PC: next_st.rd_data = cx_pkg::BUS_DW'(st.pc);
               cx_pkg::ADDR_STACK: next_st.rd_data = cx_pkg::BUS_DW'(st.stk[0]);
               cx_pkg::ADDR_DIR6: next_st.rd_data = cx_pkg::BUS_DW'(st.dir.dir6);
               cx_pkg::ADDR_DIR7: next_st.rd_data = cx_pkg::BUS_DW'(st.dir.dir7);
               cx_pkg::ADDR_WDT: next_st.rd_data = {st.pre, st.wdt};
               cx_pkg::ADDR_CORE: begin
                  next_st.rd_data[cx_pkg::CORE_SLEEP] = (st.fsm == cx_pkg::FSM_SLEEP);
                  next_st.rd_data[cx_pkg::CORE_FLUSH] = (st.fsm == cx_pkg::FSM_FLUSH);
               end
               default: next_st.rd_data = '0;
            endcase
         end
      end

      // Register writes; the core's own updates below take precedence
      if (bus_req.wr) begin
         if (!bus_req.addr[cx_pkg::ADDR_FILE_BIT]) begin
            next_st.file[bus_req.addr[4:0]] = bus_req.wdata[7:0];
         end else begin
            case (bus_req.addr)
               cx_pkg::ADDR_ACC: next_st.acc = bus_req.wdata[7:0];
               cx_pkg::ADDR_STATUS: begin
                  next_st.c = bus_req.wdata[cx_pkg::ST_C];
                  next_st.dc = bus_req.wdata[cx_pkg::ST_DC];
                  next_st.z = bus_req.wdata[cx_pkg::ST_Z];
                  next_st.wake_flag = bus_req.wdata[cx_pkg::ST_WAKE];
               end
               cx_pkg::ADDR_PC: next_st.pc = bus_req.wdata[cx_pkg::PC_W-1:0];
               cx_pkg::ADDR_STACK: begin
                  // Push: older entry moves down
                  next_st.stk[1] = st.stk[0];
                  next_st.stk[0] = bus_req.wdata[cx_pkg::PC_W-1:0];
               end
               cx_pkg::ADDR_DIR6: next_st.dir.dir6 = bus_req.wdata[7:0];
               cx_pkg::ADDR_DIR7: next_st.dir.dir7 = bus_req.wdata[7:0];
               default: next_st.rd_data = next_st.rd_data;
            endcase
         end
      end

      // Watchdog runs in every state
      next_st.pre = st.pre + cx_pkg::PRE_STEP;
      if (&st.pre) begin
         next_st.wdt = st.wdt + cx_pkg::WDT_STEP;
      end
      if (wdt_ovf) begin
         next_st.to_n = 1'b0;
      end

      case (st.fsm)
         cx_pkg::FSM_RUN: begin
            if (taken) begin
               next_st.pc = st.pc + cx_pkg::PC_STEP;
               case (op)
                  cx_pkg::OP_RET: begin
                     next_st.acc = lit;
                     next_st.pc = st.stk[0];
                     next_st.stk[0] = st.stk[1];
                     next_st.fsm = cx_pkg::FSM_FLUSH;
                  end
                  cx_pkg::OP_SLEEP: begin
                     next_st.wdt = '0;
                     next_st.pre = '0;
                     next_st.to_n = 1'b1;
                     next_st.slept_n = 1'b0;
                     next_st.fsm = cx_pkg::FSM_SLEEP;
                  end
                  cx_pkg::OP_RL, cx_pkg::OP_RR: begin
                     if (dest_file) next_st.file[fidx] = alu.res;
                     else next_st.acc = alu.res;
                     next_st.c = alu.c;
                  end
                  cx_pkg::OP_SUB: begin
                     if (dest_file) next_st.file[fidx] = alu.res;
                     else next_st.acc = alu.res;
                     next_st.c = alu.c;
                     next_st.dc = alu.dc;
                     next_st.z = alu.z;
                  end
                  cx_pkg::OP_SWAP: begin
                     if (dest_file) next_st.file[fidx] = alu.res;
                     else next_st.acc = alu.res;
                  end
                  cx_pkg::OP_DIR: begin
                     if (inst.word[0]) next_st.dir.dir7 = st.acc;
                     else next_st.dir.dir6 = st.acc;
                  end
                  cx_pkg::OP_XORL: begin
                     next_st.acc = alu.res;
                     next_st.z = alu.z;
                  end
                  cx_pkg::OP_XORF: begin
                     if (dest_file) next_st.file[fidx] = alu.res;
                     else next_st.acc = alu.res;
                     next_st.z = alu.z;
                  end
                  default: next_st.pc = st.pc + cx_pkg::PC_STEP;
               endcase
            end
         end
         cx_pkg::FSM_FLUSH: next_st.fsm = cx_pkg::FSM_RUN;
         cx_pkg::FSM_SLEEP: begin
            // Wake on synchronised pin or watchdog expiry
            if (st.wk_s2) begin
               next_st.wake_flag = 1'b1;
               next_st.fsm = cx_pkg::FSM_RUN;
            end else if (wdt_ovf) begin
               next_st.fsm = cx_pkg::FSM_RUN;
            end
         end
         default: next_st.fsm = cx_pkg::FSM_RUN;
      endcase

      next_st.inst_ready = (next_st.fsm == cx_pkg::FSM_RUN);
      next_st.osc_run = (next_st.fsm != cx_pkg::FSM_SLEEP);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st <= cx_pkg::STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign bus_rdata = st.rd_data;
   assign inst_ready = st.inst_ready;
   assign osc_run = st.osc_run;
   assign pc_out = st.pc;
   assign dir_out = st.dir;

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   logic quiet_bus;
   assign quiet_bus = !bus_req.wr;

   a_ret_acc: assert property (taken && op == cx_pkg::OP_RET && quiet_bus |=>
      st.acc == $past(lit) && st.c == $past(st.c) && st.z == $past(st.z))
      else $error("return literal did not load accumulator or moved flags");

   a_ret_pop: assert property (taken && op == cx_pkg::OP_RET && quiet_bus |=>
      st.pc == $past(st.stk[0]) && st.stk[0] == $past(st.stk[1]))
      else $error("return did not pop the stack into the program counter");

   a_ret_two_cycle: assert property (taken && op == cx_pkg::OP_RET |=>
      !inst_ready ##1 inst_ready)
      else $error("return did not take exactly two cycles");

   a_sleep_wdt_clear: assert property (taken && op == cx_pkg::OP_SLEEP |=>
      st.wdt == 8'h00 && st.pre == 8'h00)
      else $error("sleep did not clear watchdog and prescaler");

   a_sleep_flag_set: assert property (taken && op == cx_pkg::OP_SLEEP && quiet_bus |=>
      st.to_n && !st.slept_n && st.wake_flag == $past(st.wake_flag))
      else $error("sleep flags wrong");

   a_sleep_halt: assert property (taken && op == cx_pkg::OP_SLEEP ##1 !st.wk_s2 |->
      !osc_run && !inst_ready)
      else $error("core still running after sleep");

   a_rotl_result: assert property (taken && op == cx_pkg::OP_RL && !dest_file && quiet_bus |=>
      st.acc == {$past(fval[6:0]), $past(st.c)} && st.c == $past(fval[7]))
      else $error("rotate left result wrong");

   a_rotr_result: assert property (taken && op == cx_pkg::OP_RR && !dest_file && quiet_bus |=>
      st.acc == {$past(st.c), $past(fval[7:1])} && st.c == $past(fval[0]))
      else $error("rotate right result wrong");

   a_sub_borrow: assert property (taken && op == cx_pkg::OP_SUB && !dest_file && quiet_bus |=>
      st.acc == $past(fval) - $past(st.acc) && st.c == ($past(fval) >= $past(st.acc)))
      else $error("subtract result or carry wrong");

   a_dest_file_keep: assert property (taken && dest_file && quiet_bus &&
      (op == cx_pkg::OP_SUB || op == cx_pkg::OP_XORF) |=> st.acc == $past(st.acc))
      else $error("file destination disturbed the accumulator");

   a_swap_nibble: assert property (taken && op == cx_pkg::OP_SWAP && !dest_file && quiet_bus |=>
      st.acc == {$past(fval[3:0]), $past(fval[7:4])} && st.c == $past(st.c))
      else $error("nibble swap wrong");

   a_dir_load: assert property (taken && op == cx_pkg::OP_DIR && quiet_bus |=>
      (($past(inst.word[0]) ? dir_out.dir7 : dir_out.dir6) == $past(st.acc)))
      else $error("direction register not loaded from accumulator");

   a_xorl_acc: assert property (taken && op == cx_pkg::OP_XORL && quiet_bus |=>
      st.acc == ($past(st.acc) ^ $past(lit)))
      else $error("xor literal result wrong");

   a_xorf_zero: assert property (taken && op == cx_pkg::OP_XORF && quiet_bus |=>
      st.z == (($past(st.acc) ^ $past(fval)) == 8'h00) && st.c == $past(st.c))
      else $error("xor file flags wrong");

   a_ret_half_keep: assert property (taken && op == cx_pkg::OP_RET && quiet_bus |=>
      st.dc == $past(st.dc))
      else $error("return literal moved the half carry flag");

   a_flush_blocks: assert property (st.fsm == cx_pkg::FSM_FLUSH |->
      !inst_ready)
      else $error("instruction port open during flush");

   a_sleep_hold: assert property (st.fsm == cx_pkg::FSM_SLEEP && !st.wk_s2 &&
      !wdt_ovf |=> !osc_run && !inst_ready)
      else $error("core left sleep without a wake-up");

   a_sleep_frozen: assert property (st.fsm == cx_pkg::FSM_SLEEP && quiet_bus |=>
      st.acc == $past(st.acc) && st.pc == $past(st.pc))
      else $error("instruction executed while asleep");

   a_pin_wake: assert property (st.fsm == cx_pkg::FSM_SLEEP && st.wk_s2 |=>
      st.wake_flag && osc_run && inst_ready)
      else $error("pin wake-up did not resume or set its flag");

   a_rot_flags_keep: assert property (taken && quiet_bus &&
      (op == cx_pkg::OP_RL || op == cx_pkg::OP_RR) |=>
      st.z == $past(st.z) && st.dc == $past(st.dc))
      else $error("rotate moved a flag other than carry");

   a_rotl_file: assert property (taken && op == cx_pkg::OP_RL && dest_file &&
      quiet_bus |=> st.acc == $past(st.acc) &&
      st.file[$past(fidx)] == {$past(fval[6:0]), $past(st.c)})
      else $error("rotate left file destination wrong");

   a_rotr_file: assert property (taken && op == cx_pkg::OP_RR && dest_file &&
      quiet_bus |=> st.acc == $past(st.acc) &&
      st.file[$past(fidx)] == {$past(st.c), $past(fval[7:1])})
      else $error("rotate right file destination wrong");

   a_sub_flags: assert property (taken && op == cx_pkg::OP_SUB && quiet_bus |=>
      st.dc == ($past(fval[3:0]) >= $past(st.acc[3:0])) &&
      st.z == ($past(fval) == $past(st.acc)))
      else $error("subtract half carry or zero wrong");

   a_swap_keep: assert property (taken && op == cx_pkg::OP_SWAP && quiet_bus |=>
      st.z == $past(st.z) && st.dc == $past(st.dc))
      else $error("nibble swap moved a flag");

   a_dir_keep: assert property (taken && op == cx_pkg::OP_DIR && quiet_bus |=>
      st.acc == $past(st.acc) && st.c == $past(st.c) && st.z == $past(st.z))
      else $error("direction load disturbed accumulator or flags");

   a_xorf_file: assert property (taken && op == cx_pkg::OP_XORF && dest_file &&
      quiet_bus |=> st.dc == $past(st.dc) &&
      st.file[$past(fidx)] == ($past(st.acc) ^ $past(fval)))
      else $error("xor file destination wrong");

   a_xorl_zero: assert property (taken && op == cx_pkg::OP_XORL && quiet_bus |=>
      st.z == ($past(st.acc) == $past(lit)) && st.c == $past(st.c))
      else $error("xor literal zero flag wrong");

   a_pc_step: assert property (taken && op != cx_pkg::OP_RET && quiet_bus |=>
      st.pc == $past(st.pc) + cx_pkg::PC_STEP)
      else $error("program counter did not step");

   a_rd_stand: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
      else $error("read data stood beyond one cycle");

   a_wdt_step: assert property (!(taken && op == cx_pkg::OP_SLEEP) |=>
      st.pre == $past(st.pre) + cx_pkg::PRE_STEP)
      else $error("watchdog prescaler did not count");

   c_return: cover property (taken && op == cx_pkg::OP_RET ##2 inst_ready);
   c_sleep_wake: cover property (taken && op == cx_pkg::OP_SLEEP ##[1:20] osc_run);
   c_sub_borrow: cover property (taken && op == cx_pkg::OP_SUB && fval < st.acc);
   c_xor_zero: cover property (taken && op == cx_pkg::OP_XORF && fval == st.acc);
   c_pin_wake: cover property (st.fsm == cx_pkg::FSM_SLEEP && st.wk_s2);
endmodule

/* File: cx_pkg.sv */
// Constants, encodings and state carriers for the core execute subset
// Functional notes
// - Return-literal loads the accumulator with its 8-bit literal; flags untouched.
// - Return-literal reloads the program counter from the stack top and pops it.
// - Return-literal takes two instruction cycles; the second flushes the fetch.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep sets the expiry flag, clears the sleep-entered flag, keeps pin wake flag.
// - Sleep stops the oscillator and halts execution until a wake-up condition.
// - Rotate-left through carry; carry in at bit 0, bit 7 out to carry.
// - Rotate-right through carry; carry in at bit 7, bit 0 out to carry.
// - Subtract computes file minus accumulator; updates carry, half carry and zero.
// - Destination bit 0 writes the accumulator, 1 writes the addressed register.
// - Nibble swap exchanges the two nibbles, writes destination, flags untouched.
// - Direction-load copies the accumulator to direction register 6 or 7.
// - Xor-literal xors the accumulator with an 8-bit literal into the accumulator.
// - Xor-file xors accumulator with the register into destination; zero only.
package cx_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 9;
   localparam int BUS_AW = 6;
   localparam int BUS_DW = 16;
   localparam int FILE_N = 32;
   localparam int STACK_N = 2;
   localparam int WDT_W = 8;
   localparam int PRE_W = 8;
   localparam int INST_W = 12;
   localparam int RETURN_CYCLES = 2;

   // Register offsets
   localparam logic [BUS_AW-1:0] ADDR_ACC = 6'h20;
   localparam logic [BUS_AW-1:0] ADDR_STATUS = 6'h21;
   localparam logic [BUS_AW-1:0] ADDR_PC = 6'h22;
   localparam logic [BUS_AW-1:0] ADDR_STACK = 6'h23;
   localparam logic [BUS_AW-1:0] ADDR_DIR6 = 6'h24;
   localparam logic [BUS_AW-1:0] ADDR_DIR7 = 6'h25;
   localparam logic [BUS_AW-1:0] ADDR_WDT = 6'h26;
   localparam logic [BUS_AW-1:0] ADDR_CORE = 6'h27;
   localparam int ADDR_FILE_BIT = 5;

   // Status field positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_SLEPT_N = 3;
   localparam int ST_TO_N = 4;
   localparam int ST_WAKE = 7;
   // Core state field positions
   localparam int CORE_SLEEP = 0;
   localparam int CORE_FLUSH = 1;

   // Reset values and step sizes
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 9'h000;
   localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
   localparam logic [PC_W-1:0] PC_STEP = 9'h001;
   localparam logic [WDT_W-1:0] WDT_STEP = 8'h01;
   localparam logic [PRE_W-1:0] PRE_STEP = 8'h01;

   // Instruction encodings: value under mask
   localparam logic [INST_W-1:0] MASK_LIT = 12'hf00;
   localparam logic [INST_W-1:0] MASK_FD = 12'hfc0;
   localparam logic [INST_W-1:0] MASK_ALL = 12'hfff;
   localparam logic [INST_W-1:0] MASK_DIR = 12'hffe;
   localparam logic [INST_W-1:0] OPC_RET = 12'h800;
   localparam logic [INST_W-1:0] OPC_XORL = 12'hf00;
   localparam logic [INST_W-1:0] OPC_SLEEP = 12'h003;
   localparam logic [INST_W-1:0] OPC_DIR = 12'h006;
   localparam logic [INST_W-1:0] OPC_RL = 12'h340;
   localparam logic [INST_W-1:0] OPC_RR = 12'h300;
   localparam logic [INST_W-1:0] OPC_SUB = 12'h080;
   localparam logic [INST_W-1:0] OPC_SWAP = 12'h380;
   localparam logic [INST_W-1:0] OPC_XORF = 12'h180;
   localparam int INST_D_BIT = 5;

   typedef enum logic [3:0] {
      OP_NONE, OP_RET, OP_SLEEP, OP_RL, OP_RR, OP_SUB, OP_SWAP, OP_DIR, OP_XORL, OP_XORF
   } cx_op_t;

   typedef enum logic [2:0] {
      FSM_RUN = 3'b001,
      FSM_FLUSH = 3'b010,
      FSM_SLEEP = 3'b100
   } cx_fsm_t;

   typedef struct packed {
      logic [BUS_AW-1:0] addr;
      logic [BUS_DW-1:0] wdata;
      logic wr;
      logic rd;
   } cx_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [INST_W-1:0] word;
   } cx_inst_t;

   typedef struct packed {
      logic [DATA_W-1:0] dir6;
      logic [DATA_W-1:0] dir7;
   } cx_dir_t;

   typedef struct packed {
      logic [DATA_W-1:0] res;
      logic c;
      logic dc;
      logic z;
   } cx_alu_out_t;

   typedef struct packed {
      cx_fsm_t fsm;
      logic [DATA_W-1:0] acc;
      logic c;
      logic dc;
      logic z;
      logic to_n;
      logic slept_n;
      logic wake_flag;
      logic [PC_W-1:0] pc;
      logic [STACK_N-1:0][PC_W-1:0] stk;
      logic [FILE_N-1:0][DATA_W-1:0] file;
      cx_dir_t dir;
      logic [WDT_W-1:0] wdt;
      logic [PRE_W-1:0] pre;
      logic wk_s1;
      logic wk_s2;
      logic inst_ready;
      logic osc_run;
      logic [BUS_DW-1:0] rd_data;
   } cx_state_t;

   localparam cx_state_t STATE_RST = '{
      fsm: FSM_RUN, acc: ACC_RST, to_n: 1'b1, slept_n: 1'b1, pc: PC_RST,
      dir: '{dir6: DIR_RST, dir7: DIR_RST}, inst_ready: 1'b1, osc_run: 1'b1, default: '0
   };
endpackage

/* File: cx_alu.sv */
// Result and flag calculation for the execute subset
`timescale 1ns/1ps
module cx_alu (
   input wire cx_pkg::cx_op_t op,
   input wire logic [cx_pkg::DATA_W-1:0] acc,
   input wire logic [cx_pkg::DATA_W-1:0] fval,
   input wire logic [cx_pkg::DATA_W-1:0] lit,
   input wire logic c_in,
   output cx_pkg::cx_alu_out_t res
);
   logic [cx_pkg::DATA_W:0] sub_full;
   logic [4:0] sub_low;

   always_comb begin
      // File minus accumulator as file plus inverted accumulator plus one
      sub_full = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
      sub_low = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      res.c = c_in;
      res.dc = sub_low[4];
      case (op)
         cx_pkg::OP_RL: begin
            res.res = {fval[6:0], c_in};
            res.c = fval[7];
         end
         cx_pkg::OP_RR: begin
            res.res = {c_in, fval[7:1]};
            res.c = fval[0];
         end
         cx_pkg::OP_SUB: begin
            res.res = sub_full[7:0];
            res.c = sub_full[8];
         end
         cx_pkg::OP_SWAP: res.res = {fval[3:0], fval[7:4]};
         cx_pkg::OP_XORL: res.res = acc ^ lit;
         cx_pkg::OP_XORF: res.res = acc ^ fval;
         default: res.res = fval;
      endcase
      res.z = (res.res == 8'h00);
   end
endmodule

/* File: cx_exec_core_tb.sv */
// Self-checking testbench for the execute core subset
`timescale 1ns/1ps
module cx_exec_core_tb;
   logic sys_clk;
   logic rstn;
   cx_pkg::cx_bus_req_t bus_req;
   logic [cx_pkg::BUS_DW-1:0] bus_rdata;
   cx_pkg::cx_inst_t inst;
   logic inst_ready;
   logic wake_pin;
   logic osc_run;
   logic [cx_pkg::PC_W-1:0] pc_out;
   cx_pkg::cx_dir_t dir_out;
   int miscompares;
   int cmp_count;

   cx_exec_core u_cx_exec_core (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .inst(inst),
      .inst_ready(inst_ready),
      .wake_pin(wake_pin),
      .osc_run(osc_run),
      .pc_out(pc_out),
      .dir_out(dir_out)
   );

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The bus, issue and exec tasks enter and leave just after a rising edge
   task automatic bus_wr(input logic [cx_pkg::BUS_AW-1:0] addr, input logic [15:0] data);
      bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic bus_rd(input logic [cx_pkg::BUS_AW-1:0] addr, input logic [15:0] exp);
      bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      @(negedge sys_clk);
      chk(bus_rdata, exp);
      @(posedge sys_clk);
   endtask

   // Leaves right after the edge that takes the word
   task automatic issue(input logic [11:0] word);
      int i;
      for (i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         if (inst_ready === 1'b1) break;
      end
      if (i == 40) begin
         miscompares++;
         print_verdict();
      end
      @(posedge sys_clk);
      inst <= '{valid: 1'b1, word: word};
      @(posedge sys_clk);
      inst <= '0;
   endtask

   // File register 3 is the operand; checks accumulator, file and flags
   task automatic exec(input logic [11:0] word, input logic [7:0] f, input logic [7:0] a,
         input logic [7:0] st, input logic [7:0] exp_a, input logic [7:0] exp_f,
         input logic [7:0] exp_st);
      bus_wr(6'h03, {8'h00, f});
      bus_wr(cx_pkg::ADDR_ACC, {8'h00, a});
      bus_wr(cx_pkg::ADDR_STATUS, {8'h00, st});
      issue(word);
      bus_rd(cx_pkg::ADDR_ACC, {8'h00, exp_a});
      bus_rd(6'h03, {8'h00, exp_f});
      bus_rd(cx_pkg::ADDR_STATUS, {8'h00, exp_st | 8'h18});
   endtask

   initial begin
      int i;
      miscompares = 0;
      cmp_count = 0;
      rstn = 1'b0;
      bus_req = '0;
      inst = '0;
      wake_pin = 1'b0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      // Reset state and an unmapped place
      bus_rd(cx_pkg::ADDR_ACC, 16'h0000);
      bus_rd(cx_pkg::ADDR_STATUS, 16'h0018);
      bus_rd(cx_pkg::ADDR_PC, 16'h0000);
      chk({8'h00, dir_out.dir6}, 16'h00ff);
      chk({15'h0000, osc_run}, 16'h0001);
      bus_wr(6'h30, 16'h00aa);
      bus_rd(6'h30, 16'h0000);
      // Return with literal: two stack entries, flags set beforehand
      bus_wr(cx_pkg::ADDR_STACK, 16'h00aa);
      bus_wr(cx_pkg::ADDR_STACK, 16'h0123);
      bus_wr(cx_pkg::ADDR_ACC, 16'h0055);
      bus_wr(cx_pkg::ADDR_STATUS, 16'h0007);
      issue(12'h8a5);
      @(negedge sys_clk);
      chk({15'h0000, inst_ready}, 16'h0000);
      chk({7'h00, pc_out}, 16'h0123);
      @(negedge sys_clk);
      chk({15'h0000, inst_ready}, 16'h0001);
      @(posedge sys_clk);
      bus_rd(cx_pkg::ADDR_ACC, 16'h00a5);
      bus_rd(cx_pkg::ADDR_STATUS, 16'h001f);
      bus_rd(cx_pkg::ADDR_STACK, 16'h00aa);
      // Register operations, both destinations
      exec(12'h343, 8'h81, 8'h33, 8'h06, 8'h02, 8'h81, 8'h07);
      exec(12'h363, 8'h40, 8'h33, 8'h01, 8'h33, 8'h81, 8'h00);
      exec(12'h303, 8'h01, 8'h33, 8'h06, 8'h00, 8'h01, 8'h07);
      exec(12'h323, 8'h02, 8'h33, 8'h01, 8'h33, 8'h81, 8'h00);
      exec(12'h083, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h10, 8'h01);
      exec(12'h0a3, 8'h22, 8'h22, 8'h00, 8'h22, 8'h00, 8'h07);
      exec(12'h083, 8'h01, 8'h02, 8'h07, 8'hff, 8'h01, 8'h00);
      exec(12'h383, 8'ha5, 8'h33, 8'h05, 8'h5a, 8'ha5, 8'h05);
      exec(12'h3a3, 8'h3c, 8'h33, 8'h02, 8'h33, 8'hc3, 8'h02);
      exec(12'h183, 8'hf0, 8'h0f, 8'h03, 8'hff, 8'hf0, 8'h03);
      exec(12'h1a3, 8'h5a, 8'h5a, 8'h03, 8'h5a, 8'h00, 8'h07);
      exec(12'hf3c, 8'h11, 8'h3c, 8'h03, 8'h00, 8'h11, 8'h07);
      exec(12'hfff, 8'h11, 8'h0f, 8'h07, 8'hf0, 8'h11, 8'h03);
      // Direction loads
      exec(12'h006, 8'h11, 8'h12, 8'h05, 8'h12, 8'h11, 8'h05);
      chk({8'h00, dir_out.dir6}, 16'h0012);
      chk({8'h00, dir_out.dir7}, 16'h00ff);
      exec(12'h007, 8'h11, 8'h34, 8'h02, 8'h34, 8'h11, 8'h02);
      chk({8'h00, dir_out.dir7}, 16'h0034);
      chk({8'h00, dir_out.dir6}, 16'h0012);
      // Sleep with the pin wake flag already set
      bus_wr(cx_pkg::ADDR_STATUS, 16'h0081);
      bus_wr(cx_pkg::ADDR_ACC, 16'h0066);
      issue(12'h003);
      bus_rd(cx_pkg::ADDR_WDT, 16'h0000);
      @(negedge sys_clk);
      chk({15'h0000, osc_run}, 16'h0000);
      chk({15'h0000, inst_ready}, 16'h0000);
      @(posedge sys_clk);
      bus_rd(cx_pkg::ADDR_STATUS, 16'h0091);
      bus_rd(cx_pkg::ADDR_CORE, 16'h0001);
      // Word offered while asleep must be ignored
      inst <= '{valid: 1'b1, word: 12'hfff};
      repeat (2) @(posedge sys_clk);
      inst <= '0;
      wake_pin <= 1'b1;
      for (i = 0; i < 10; i++) begin
         @(negedge sys_clk);
         if (osc_run === 1'b1) break;
      end
      if (i == 10) begin
         miscompares++;
         print_verdict();
      end
      chk({15'h0000, inst_ready}, 16'h0001);
      @(posedge sys_clk);
      wake_pin <= 1'b0;
      bus_rd(cx_pkg::ADDR_ACC, 16'h0066);
      bus_rd(cx_pkg::ADDR_STATUS, 16'h0091);
      bus_rd(cx_pkg::ADDR_CORE, 16'h0000);
      // Undecoded word only steps the program counter
      issue(12'h000);
      bus_rd(cx_pkg::ADDR_PC, 16'h0134);
      bus_rd(cx_pkg::ADDR_ACC, 16'h0066);
      print_verdict();
   end
endmodule
